// ===== adc_status_defs.vh
// Purpose: constants for the converter status, pin and format block
// Assumes: 8-bit serial register port, 24-bit status and enable words
// Notes:   register addresses are local choices, see hand-over
`ifndef ADC_STATUS_DEFS_VH
`define ADC_STATUS_DEFS_VH

`define ADDR_STATUS       8'h00
`define ADDR_STATUS_IE    8'h01
`define ADDR_PIN0_CTRL    8'h02
`define ADDR_PIN1_CTRL    8'h03
`define ADDR_CTRL         8'h04
`define ADDR_RESULT_BASE  8'h10

`define STATUS_IE_RESET   24'h000001
`define PIN_CTRL_RESET    8'h00
`define CTRL_RESET        8'h00

// Status bit positions
`define ST_CONV_RDY       0
`define ST_DATA_RDY       1
`define ST_SYSGOR         2
`define ST_BUSY           3
`define ST_TOR_LSB        8
`define ST_TUR_LSB        16

// Pin control fields
`define PC_DIR_LSB        0
`define PC_OSEL_LSB       2
`define DIR_INPUT         2'h0
`define DIR_CMOS          2'h1
`define DIR_OPEN_DRAIN    2'h2
`define OSEL_IRQ          3'h0
`define OSEL_MUX          3'h1
`define OSEL_MOD_CLK      3'h2
`define OSEL_LOW          3'h3
`define OSEL_HIGH         3'h4
`define OSEL_AUTO_SW      3'h5
`define ISEL_CONV         3'h0
`define ISEL_SEQ          3'h1

// Converter control fields
`define CTRL_FORMAT       0
`define CTRL_POLARITY     1

`define CODE_MAX          24'hFFFFFF
`define CODE_MIN          24'h000000
`define CODE_MID          24'h800000
`define CODE_POS_MAX      24'h7FFFFF

`endif

// ===== aux_pin_ctrl.v
// Purpose: one auxiliary pin: input trigger or selectable output
// Assumes: pin input synchronous to sys_clk
// Notes:   open-drain mode only ever drives low
`timescale 1ns/100ps
`include "adc_status_defs.vh"
module aux_pin_ctrl (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       arst_n,
    // Configuration and sources
    input  wire [7:0] ctrl,
    input  wire       irq_level,
    input  wire       mux_level,
    input  wire       mod_clk,
    input  wire       busy,
    // Pin
    input  wire       pin_in,
    output reg        pin_out,
    output reg        pin_oe,
    // Triggers
    output wire       conv_start,
    output wire       seq_start
);
    wire [1:0] dir = ctrl[`PC_DIR_LSB+1:`PC_DIR_LSB];
    wire [2:0] sel = ctrl[`PC_OSEL_LSB+2:`PC_OSEL_LSB];
    reg        level;
    reg        prev_reg;

    always @* begin
        case (sel)
            `OSEL_IRQ:     level = irq_level;
            `OSEL_MUX:     level = mux_level;
            `OSEL_MOD_CLK: level = mod_clk;
            `OSEL_LOW:     level = 1'b0;
            `OSEL_HIGH:    level = 1'b1;
            `OSEL_AUTO_SW: level = ~busy;
            default:       level = 1'b1;
        endcase
    end

    // Registered so the pin cannot glitch on select changes
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out  <= 1'b0;
            pin_oe   <= 1'b0;
            // High so a pin already high at release gives no start
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= pin_in;
            case (dir)
                `DIR_CMOS: begin
                    pin_out <= level;
                    pin_oe  <= 1'b1;
                end
                `DIR_OPEN_DRAIN: begin
                    pin_out <= 1'b0;
                    pin_oe  <= ~level;
                end
                default: begin
                    pin_out <= 1'b0;
                    pin_oe  <= 1'b0;
                end
            endcase
        end
    end

    // Rising edge on an input pin starts a conversion or sequence
    wire rise = (dir == `DIR_INPUT) && pin_in && !prev_reg;
    assign conv_start = rise && (sel == `ISEL_CONV);
    assign seq_start  = rise && (sel == `ISEL_SEQ);
endmodule

// ===== adc_status_gpio_format.v
// Purpose: status flags, interrupt, aux pins and result formatting
// Assumes: 8-bit register port; results arrive with a write strobe
// Notes:   24-bit registers are read as three byte lanes
//
// Summary of operation
// - Direction 0b10 makes a pin open-drain; input and CMOS also allowed.
// - Output select 0b101 makes the pin an automatic low-side switch.
// - Output select 0b011 drives low, 0b100 releases high.
// - An input pin can trigger a single conversion or a sequence.
// - An output pin can carry interrupt, mux level or modulator clock.
// - Status reports state and interrupt cause; reading clears most flags.
// - Per-result over-range flag sets above threshold, clears on status read.
// - Per-result under-range flag sets below threshold, clears on status read.
// - Gain calibration over-range flag clears on read or valid recalibration.
// - Unread flag is OR of eight per-result flags, cleared by result reads.
// - Interrupt is OR of status bits gated by matching enable bits.
// - Interrupt enable resets to 0x000001, only conversion ready.
// - Unipolar gives straight binary, clamps negatives, ignores format.
// - Bipolar: format 1 offset binary, format 0 two's complement.
// - Bipolar codes saturate at documented full-scale limits.
// - Calibration uses the current rate; software picks a slow one.
`timescale 1ns/100ps
`include "adc_status_defs.vh"
module adc_status_gpio_format #(
    parameter NUM_RESULTS = 8
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        arst_n,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [1:0]  reg_lane,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // Converter core
    input  wire        conv_busy,
    input  wire        conv_done,
    input  wire        result_wr,
    input  wire [2:0]  result_idx,
    input  wire signed [24:0] result_raw,
    input  wire        result_over,
    input  wire        result_under,
    input  wire        cal_gain_done,
    input  wire [24:0] cal_gain_coef,
    input  wire        mux_level,
    input  wire        mod_clk,
    // Aux pins
    input  wire        aux_pin0_in,
    output wire        aux_pin0_out,
    output wire        aux_pin0_oe,
    input  wire        aux_pin1_in,
    output wire        aux_pin1_out,
    output wire        aux_pin1_oe,
    // Triggers and interrupt
    output wire        conv_start,
    output wire        seq_start,
    output reg         serial_out_irq_pin
);
    reg [23:0] status_interrupt_enable_reg;
    reg [7:0]  aux_pin0_control_reg;
    reg [7:0]  aux_pin1_control_reg;
    reg [7:0]  converter_control_reg;
    reg [NUM_RESULTS-1:0] tor_reg;
    reg [NUM_RESULTS-1:0] tur_reg;
    reg [NUM_RESULTS-1:0] unread_reg;
    reg        conv_rdy_reg;
    reg        sysgor_reg;
    reg [23:0] result_regs [0:NUM_RESULTS-1];
    reg [23:0] upper_threshold_regs [0:NUM_RESULTS-1];
    reg [23:0] lower_threshold_regs [0:NUM_RESULTS-1];
    reg [23:0] fmt_code;
    wire [23:0] converter_status;

    function [7:0] lane_of;
        input [23:0] word;
        input [1:0]  lane;
        begin
            case (lane)
                2'h0:    lane_of = word[7:0];
                2'h1:    lane_of = word[15:8];
                2'h2:    lane_of = word[23:16];
                default: lane_of = 8'h00;
            endcase
        end
    endfunction

    function [23:0] lane_put;
        input [23:0] word;
        input [1:0]  lane;
        input [7:0]  data;
        begin
            lane_put = word;
            case (lane)
                2'h0:    lane_put[7:0]   = data;
                2'h1:    lane_put[15:8]  = data;
                2'h2:    lane_put[23:16] = data;
                default: lane_put = word;
            endcase
        end
    endfunction

    // Decodes used by both register and flag logic
    wire status_rd = reg_rd && (reg_addr == `ADDR_STATUS);
    wire in_results = (reg_addr >= `ADDR_RESULT_BASE) &&
                      (reg_addr < `ADDR_RESULT_BASE + 8'h18);
    wire [7:0] roff = reg_addr - `ADDR_RESULT_BASE;
    wire [2:0] ridx = roff[2:0];
    wire [1:0] rgrp = roff[4:3];
    // Unread flag clears once the top byte of a result is read
    wire result_rd = reg_rd && in_results && (rgrp == 2'h0) &&
                     (reg_lane == 2'h2);

    // Output formatting of the raw signed value
    always @* begin
        if (converter_control_reg[`CTRL_POLARITY]) begin
            if (result_raw[24])
                fmt_code = `CODE_MIN;
            else if (result_raw[23])
                fmt_code = `CODE_MAX;
            else
                fmt_code = {result_raw[22:0], 1'b0};
        end else if (result_raw > $signed(25'h07FFFFF)) begin
            fmt_code = converter_control_reg[`CTRL_FORMAT] ?
                       `CODE_MAX : `CODE_POS_MAX;
        end else if (result_raw < $signed(25'h1800000)) begin
            fmt_code = converter_control_reg[`CTRL_FORMAT] ?
                       `CODE_MIN : `CODE_MID;
        end else if (converter_control_reg[`CTRL_FORMAT]) begin
            fmt_code = {~result_raw[23], result_raw[22:0]};
        end else begin
            fmt_code = result_raw[23:0];
        end
    end

    // Threshold compare on the formatted code, per result slot
    wire tor_hit = (fmt_code > upper_threshold_regs[result_idx]) ||
                   result_over;
    wire tur_hit = (fmt_code < lower_threshold_regs[result_idx]) ||
                   result_under;
    wire gain_bad = cal_gain_coef[24];

    genvar g;
    generate
        for (g = 0; g < NUM_RESULTS; g = g + 1) begin : slot
            wire hit = result_wr && (result_idx == g);
            always @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    tor_reg[g]    <= 1'b0;
                    tur_reg[g]    <= 1'b0;
                    unread_reg[g] <= 1'b0;
                    result_regs[g] <= 24'h000000;
                    // Thresholds come up fully open so nothing trips
                    upper_threshold_regs[g] <= `CODE_MAX;
                    lower_threshold_regs[g] <= `CODE_MIN;
                end else begin
                    // Set beats clear so no event is lost
                    if (hit && tor_hit)
                        tor_reg[g] <= 1'b1;
                    else if (status_rd)
                        tor_reg[g] <= 1'b0;
                    if (hit && tur_hit)
                        tur_reg[g] <= 1'b1;
                    else if (status_rd)
                        tur_reg[g] <= 1'b0;
                    if (hit)
                        unread_reg[g] <= 1'b1;
                    else if (result_rd && ridx == g)
                        unread_reg[g] <= 1'b0;
                    if (hit)
                        result_regs[g] <= fmt_code;
                    if (reg_wr && in_results && ridx == g &&
                        rgrp == 2'h1)
                        upper_threshold_regs[g] <= lane_put(
                            upper_threshold_regs[g], reg_lane, reg_wdata);
                    if (reg_wr && in_results && ridx == g &&
                        rgrp == 2'h2)
                        lower_threshold_regs[g] <= lane_put(
                            lower_threshold_regs[g], reg_lane, reg_wdata);
                end
            end
        end
    endgenerate

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_rdy_reg <= 1'b0;
            sysgor_reg   <= 1'b0;
        end else begin
            if (conv_done)
                conv_rdy_reg <= 1'b1;
            else if (status_rd)
                conv_rdy_reg <= 1'b0;
            if (cal_gain_done && gain_bad)
                sysgor_reg <= 1'b1;
            else if (status_rd || cal_gain_done)
                sysgor_reg <= 1'b0;
        end
    end

    // Calibration runs at the rate the filter currently holds
    // Busy is a live level, so a status read never clears it
    assign converter_status = {tur_reg, tor_reg, 4'h0, conv_busy,
                               sysgor_reg, |unread_reg, conv_rdy_reg};

    // Configuration writes, one byte at a time
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_interrupt_enable_reg <= `STATUS_IE_RESET;
            aux_pin0_control_reg  <= `PIN_CTRL_RESET;
            aux_pin1_control_reg  <= `PIN_CTRL_RESET;
            converter_control_reg <= `CTRL_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_STATUS_IE: status_interrupt_enable_reg <= lane_put(
                    status_interrupt_enable_reg, reg_lane, reg_wdata);
                `ADDR_PIN0_CTRL: aux_pin0_control_reg  <= reg_wdata;
                `ADDR_PIN1_CTRL: aux_pin1_control_reg  <= reg_wdata;
                `ADDR_CTRL:      converter_control_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data registered one cycle after the strobe
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            serial_out_irq_pin <= 1'b0;
        end else begin
            serial_out_irq_pin <= |(converter_status &
                                    status_interrupt_enable_reg);
            if (reg_rd) begin
                if (in_results) begin
                    case (rgrp)
                        2'h0: reg_rdata <= lane_of(result_regs[ridx],
                                                   reg_lane);
                        2'h1: reg_rdata <= lane_of(
                            upper_threshold_regs[ridx], reg_lane);
                        default: reg_rdata <= lane_of(
                            lower_threshold_regs[ridx], reg_lane);
                    endcase
                end else begin
                    case (reg_addr)
                        `ADDR_STATUS: reg_rdata <=
                            lane_of(converter_status, reg_lane);
                        `ADDR_STATUS_IE: reg_rdata <=
                            lane_of(status_interrupt_enable_reg, reg_lane);
                        `ADDR_PIN0_CTRL: reg_rdata <= aux_pin0_control_reg;
                        `ADDR_PIN1_CTRL: reg_rdata <= aux_pin1_control_reg;
                        `ADDR_CTRL:      reg_rdata <= converter_control_reg;
                        default:         reg_rdata <= 8'h00;
                    endcase
                end
            end
        end
    end

    wire start0;
    wire start1;
    wire seq0;
    wire seq1;

    aux_pin_ctrl pin0 (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .ctrl       (aux_pin0_control_reg),
        .irq_level  (serial_out_irq_pin),
        .mux_level  (mux_level),
        .mod_clk    (mod_clk),
        .busy       (conv_busy),
        .pin_in     (aux_pin0_in),
        .pin_out    (aux_pin0_out),
        .pin_oe     (aux_pin0_oe),
        .conv_start (start0),
        .seq_start  (seq0)
    );

    aux_pin_ctrl pin1 (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .ctrl       (aux_pin1_control_reg),
        .irq_level  (serial_out_irq_pin),
        .mux_level  (mux_level),
        .mod_clk    (mod_clk),
        .busy       (conv_busy),
        .pin_in     (aux_pin1_in),
        .pin_out    (aux_pin1_out),
        .pin_oe     (aux_pin1_oe),
        .conv_start (start1),
        .seq_start  (seq1)
    );

    assign conv_start = start0 | start1;
    assign seq_start  = seq0 | seq1;
endmodule

// ===== adc_status_sva.sv
// Purpose: port checks for the status, pin and format block
// Assumes: irq and pin outputs move two edges after strobes, one after live levels
// Notes:   control fields are hidden here, so pin checks stay loose
`timescale 1ns/100ps
module adc_status_sva #(
    parameter NUM_RESULTS = 8
) (
    // Clock and reset
    input wire       sys_clk,
    input wire       arst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [1:0] reg_lane,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Core and pins
    input wire       conv_busy,
    input wire       conv_done,
    input wire       result_wr,
    input wire       cal_gain_done,
    input wire       mux_level,
    input wire       mod_clk,
    input wire       aux_pin0_in,
    input wire       aux_pin1_in,
    input wire       aux_pin0_oe,
    input wire       conv_start,
    input wire       seq_start,
    input wire       serial_out_irq_pin
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence lane3_read;
        reg_rd && reg_lane == 2'h3 &&
            (reg_addr < 8'h02 || reg_addr >= 8'h10);
    endsequence
    sequence hole_read;
        reg_rd && reg_addr inside {[8'h05:8'h0F]};
    endsequence
    // Any of these may change status, which reaches irq one edge later
    sequence irq_cause;
        $past(conv_done, 2) || $past(result_wr, 2) || $past(reg_wr, 2)
            || $past(cal_gain_done, 2)
            || $past(conv_busy) != $past(conv_busy, 2);
    endsequence

    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read byte moved without a read");
    lane_three_a: assert property (lane3_read |=> reg_rdata == 8'h00)
        else $error("lane three read not zero");
    hole_zero_a: assert property (hole_read |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    conv_trig_a: assert property (conv_start |->
        $rose(aux_pin0_in) || $rose(aux_pin1_in))
        else $error("conversion start without pin edge");
    seq_trig_a: assert property (seq_start |->
        $rose(aux_pin0_in) || $rose(aux_pin1_in))
        else $error("sequence start without pin edge");
    irq_rise_a: assert property ($rose(serial_out_irq_pin) |-> irq_cause)
        else $error("irq rose without a status cause");
    irq_fall_a: assert property ($fell(serial_out_irq_pin) |->
        $past(reg_rd, 2) || $past(reg_wr, 2) || $past(cal_gain_done, 2)
        || $past(conv_busy) != $past(conv_busy, 2))
        else $error("irq fell without a register access");
    pin_drive_a: assert property ($changed(aux_pin0_oe) |->
        $past(reg_wr, 2) || $past(reg_wr, 3)
        || $past(conv_busy) != $past(conv_busy, 2)
        || $past(mux_level) != $past(mux_level, 2)
        || $past(mod_clk) != $past(mod_clk, 2)
        || $past(serial_out_irq_pin) != $past(serial_out_irq_pin, 2))
        else $error("pin enable moved without cause");
endmodule

bind adc_status_gpio_format adc_status_sva #(
    .NUM_RESULTS(NUM_RESULTS)
) u_sva (.sys_clk, .arst_n, .reg_addr, .reg_lane, .reg_wr, .reg_rd,
    .reg_rdata, .conv_busy, .conv_done, .result_wr, .cal_gain_done,
    .mux_level, .mod_clk,
    .aux_pin0_in, .aux_pin1_in, .aux_pin0_oe, .conv_start, .seq_start,
    .serial_out_irq_pin);

// ===== host_regport.sv
// Purpose: host side of the byte-wide register port
// Assumes: one strobe per byte, changed only at the falling edge
// Notes:   released address and data are inverted so stale values show
`timescale 1ns/100ps
module host_regport (
    // Clock
    input  wire        sys_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [1:0] reg_lane,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_wdata,
    input  wire  [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_lane = 2'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // Configuration is always written one byte at a time
    task automatic wr(input logic [7:0] a, l, d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_lane = l[1:0];
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, l, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_lane = l[1:0];
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

// ===== adc_status_gpio_format_bench.sv
// Purpose: self-checking bench for the status, pin and format block
// Assumes: host model owns the register port; pin 0 has a pull-up
// Notes:   row table covers code formats, hand tests cover flags and pins
`timescale 1ns/100ps
`include "adc_status_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    err_total++; $display("BAD %0t mismatch line %0d", $time, `__LINE__); \
    end end
module adc_status_gpio_format_bench;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [24:0] raw;
        logic [23:0] code;
    } row_t;
    logic        sys_clk = 0;
    logic        arst_n = 0;
    logic        conv_busy = 0, conv_done = 0, result_wr = 0;
    logic        result_over = 0, result_under = 0, cal_gain_done = 0;
    logic        mux_level = 0, mod_clk = 0, pin0_ext = 1, pin1_ext = 0;
    logic [2:0]  result_idx = 0;
    logic [24:0] result_raw = 0, cal_gain_coef = 0;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire  [1:0]  reg_lane;
    wire         reg_wr, reg_rd, p0_out, p0_oe, p1_out, p1_oe, irq;
    wire         conv_start, seq_start;
    wire         pin0 = p0_oe ? p0_out : pin0_ext;
    wire         pin1 = p1_oe ? p1_out : pin1_ext;
    int          err_total = 0, cmp_count = 0, cyc = 0;
    logic [7:0]  b;
    logic [23:0] w;
    row_t rows[10] = '{
        '{8'h00, 25'h0000000, 24'h000000}, '{8'h00, 25'h1FFFFFF, 24'hFFFFFF},
        '{8'h00, 25'h0800000, 24'h7FFFFF}, '{8'h00, 25'h1000000, 24'h800000},
        '{8'h01, 25'h0000000, 24'h800000}, '{8'h01, 25'h07FFFFF, 24'hFFFFFF},
        '{8'h01, 25'h1800000, 24'h000000}, '{8'h02, 25'h0400000, 24'h800000},
        '{8'h02, 25'h1FFFFFB, 24'h000000}, '{8'h03, 25'h0800000, 24'hFFFFFF}};

    host_regport u_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_lane(reg_lane), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    adc_status_gpio_format u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_lane(reg_lane), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_busy(conv_busy), .conv_done(conv_done), .result_wr(result_wr),
        .result_idx(result_idx), .result_raw(result_raw),
        .result_over(result_over), .result_under(result_under),
        .cal_gain_done(cal_gain_done), .cal_gain_coef(cal_gain_coef),
        .mux_level(mux_level), .mod_clk(mod_clk), .aux_pin0_in(pin0),
        .aux_pin0_out(p0_out), .aux_pin0_oe(p0_oe), .aux_pin1_in(pin1),
        .aux_pin1_out(p1_out), .aux_pin1_oe(p1_oe), .conv_start(conv_start),
        .seq_start(seq_start), .serial_out_irq_pin(irq));

    always #5 sys_clk = ~sys_clk;

    task automatic test_done;
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    task automatic put(input logic [2:0] i, input logic [24:0] r,
                       input logic o, u);
        @(negedge sys_clk);
        result_idx = i;
        result_raw = r;
        result_over = o;
        result_under = u;
        result_wr = 1;
        @(negedge sys_clk);
        result_wr = 0;
        result_over = 0;
        result_under = 0;
    endtask

    task automatic rd24(input logic [7:0] a, output logic [23:0] v);
        u_host.rd(a, 0, v[7:0]);
        u_host.rd(a, 1, v[15:8]);
        u_host.rd(a, 2, v[23:16]);
    endtask

    task automatic wr24(input logic [7:0] a, input logic [23:0] v);
        u_host.wr(a, 0, v[7:0]);
        u_host.wr(a, 1, v[15:8]);
        u_host.wr(a, 2, v[23:16]);
    endtask

    task automatic pulse_done;
        @(negedge sys_clk);
        conv_done = 1;
        @(negedge sys_clk);
        conv_done = 0;
    endtask

    task automatic cal(input logic [24:0] c);
        @(negedge sys_clk);
        cal_gain_coef = c;
        cal_gain_done = 1;
        @(negedge sys_clk);
        cal_gain_done = 0;
    endtask

    task automatic pin_cfg(input logic [7:0] a, v);
        u_host.wr(a, 0, v);
        repeat (2) @(negedge sys_clk);
    endtask

    initial begin
        repeat (4) @(negedge sys_clk);
        arst_n = 1;
        `CHK({reg_rdata, irq, p0_oe, p1_oe}, 11'h000)
        rd24(`ADDR_STATUS_IE, w);
        `CHK(w, 24'h000001)
        u_host.rd(8'h7F, 0, b);
        `CHK(b, 8'h00)
        u_host.rd(`ADDR_STATUS_IE, 3, b);
        `CHK(b, 8'h00)
        wr24(8'h18, 24'hFFFFFF);
        wr24(8'h20, 24'h000000);
        foreach (rows[i]) begin
            u_host.wr(`ADDR_CTRL, 0, rows[i].ctrl);
            put(0, rows[i].raw, 0, 0);
            rd24(`ADDR_RESULT_BASE, w);
            `CHK(w, rows[i].code)
        end
        // Over-range by fault on slot 2, by threshold on slot 3
        wr24(8'h1B, 24'h000010);
        put(2, 25'h0000000, 1, 0);
        put(3, 25'h0000100, 0, 0);
        u_host.rd(`ADDR_STATUS, 1, b);
        `CHK(b, 8'h0C)
        u_host.rd(`ADDR_STATUS, 1, b);
        `CHK(b, 8'h00)
        u_host.rd(`ADDR_STATUS, 0, b);
        `CHK(b, 8'h02)
        u_host.rd(8'h12, 2, b);
        u_host.rd(8'h13, 2, b);
        wr24(8'h25, 24'h000100);
        put(5, 25'h0000000, 0, 0);
        put(6, 25'h0400000, 0, 1);
        u_host.rd(`ADDR_STATUS, 2, b);
        `CHK(b, 8'h60)
        u_host.rd(8'h15, 2, b);
        u_host.rd(8'h16, 2, b);
        u_host.rd(`ADDR_STATUS, 2, b);
        `CHK(b, 8'h00)
        u_host.rd(`ADDR_STATUS, 0, b);
        `CHK(b, 8'h00)
        cal(25'h1000000);
        u_host.rd(`ADDR_STATUS, 0, b);
        `CHK(b, 8'h04)
        cal(25'h1000000);
        cal(25'h0800000);
        u_host.rd(`ADDR_STATUS, 0, b);
        `CHK(b, 8'h00)
        pulse_done();
        repeat (2) @(negedge sys_clk);
        `CHK(irq, 1'b1)
        u_host.wr(`ADDR_STATUS_IE, 0, 8'h00);
        repeat (2) @(negedge sys_clk);
        `CHK(irq, 1'b0)
        u_host.wr(`ADDR_STATUS_IE, 0, 8'h01);
        fork
            u_host.rd(`ADDR_STATUS, 0, b);
            pulse_done();
        join
        u_host.rd(`ADDR_STATUS, 0, b);
        `CHK(b, 8'h01)
        repeat (2) @(negedge sys_clk);
        `CHK(irq, 1'b0)
        conv_busy = 1;
        u_host.rd(`ADDR_STATUS, 0, b);
        `CHK(b, 8'h08)
        conv_busy = 0;
        pin_cfg(`ADDR_PIN0_CTRL, 8'h0E);
        `CHK({p0_oe, p0_out}, 2'b10)
        pin_cfg(`ADDR_PIN0_CTRL, 8'h12);
        `CHK(p0_oe, 1'b0)
        pin_cfg(`ADDR_PIN0_CTRL, 8'h16);
        `CHK(p0_oe, 1'b0)
        conv_busy = 1;
        repeat (2) @(negedge sys_clk);
        `CHK({p0_oe, p0_out}, 2'b10)
        conv_busy = 0;
        repeat (2) @(negedge sys_clk);
        `CHK(p0_oe, 1'b0)
        pin_cfg(`ADDR_PIN0_CTRL, 8'h05);
        mux_level = 1;
        repeat (2) @(negedge sys_clk);
        `CHK({p0_oe, p0_out}, 2'b11)
        pin_cfg(`ADDR_PIN0_CTRL, 8'h09);
        mod_clk = 1;
        repeat (2) @(negedge sys_clk);
        `CHK(p0_out, 1'b1)
        mod_clk = 0;
        repeat (2) @(negedge sys_clk);
        `CHK(p0_out, 1'b0)
        pin_cfg(`ADDR_PIN0_CTRL, 8'h01);
        pulse_done();
        repeat (3) @(negedge sys_clk);
        `CHK(p0_out, 1'b1)
        pin1_ext = 1;
        #1;
        `CHK({conv_start, seq_start}, 2'b10)
        @(negedge sys_clk);
        `CHK(conv_start, 1'b0)
        pin_cfg(`ADDR_PIN1_CTRL, 8'h04);
        pin1_ext = 0;
        @(negedge sys_clk);
        pin1_ext = 1;
        #1;
        `CHK({conv_start, seq_start}, 2'b01)
        pin_cfg(`ADDR_PIN1_CTRL, 8'h0D);
        `CHK({p1_oe, p1_out}, 2'b10)
        test_done();
    end
endmodule
